// ### hw/eeprom_host_consts.vh
// constants for the eeprom host controller
`ifndef EEPROM_HOST_CONSTS_VH
`define EEPROM_HOST_CONSTS_VH
`define CLK_MHZ          40
`define ADDR_W           9
`define DATA_W           8
`define ARRAY_BYTES      512
`define T_VPS_US         5
`define T_PULSE_MS       1
`define T_PULSE_MAX_MS   10
`define T_SETUP_NS       260
`define T_READ_NS        800
`define T_CEH_NS         1400
`define ENDURANCE        10000
`define VPS_CYC          (`T_VPS_US * `CLK_MHZ)
`define PULSE_CYC        (`T_PULSE_MS * 1000 * `CLK_MHZ)
`define PULSE_MAX_CYC    (`T_PULSE_MAX_MS * 1000 * `CLK_MHZ)
`define SETUP_CYC        ((`T_SETUP_NS * `CLK_MHZ + 999) / 1000)
`define READ_CYC         ((`T_READ_NS * `CLK_MHZ + 999) / 1000)
`define CEH_CYC          ((`T_CEH_NS * `CLK_MHZ + 999) / 1000)
`define WAIT_W           20
`define WEAR_W           14
`define OP_READ          2'h0
`define OP_ERASE         2'h1
`define OP_WRITE         2'h2
`endif

// ### hw/wait_timer.v
// down counter that times one interval in clock cycles
`timescale 1ns/1ps
module wait_timer (
	clk,
	rst_b,
	load,
	count,
	done
);
`include "eeprom_host_consts.vh"
	input  wire               clk;   // system clock
	input  wire               rst_b; // sync reset, active low
	input  wire               load;  // start a new interval
	input  wire [`WAIT_W-1:0] count; // cycles to wait
	output wire               done;  // interval over, level
	reg [`WAIT_W-1:0] remain;        // cycles left
	// ---------------------------------------------
	// countdown
	// ---------------------------------------------
	always @(posedge clk) begin
		if (!rst_b)
			remain <= {`WAIT_W{1'b0}};
		else if (load)
			remain <= count;
		else if (remain != {`WAIT_W{1'b0}})
			remain <= remain - 1'b1;
	end
	assign done = (remain == {`WAIT_W{1'b0}}) && !load;
endmodule

// ### hw/eeprom_host.v
// host controller sequencing read, erase and write of a 512x8 eeprom
// Function
// RQ1 - array is 512 bytes, 9-bit address
// RQ2 - raise supply and select before programming
// RQ3 - gate low erases, strobe low writes
// RQ4 - read only at normal supply level
// RQ5 - strobe falling edge captures read address
// RQ6 - device drives data only with gate low
// RQ7 - select qualifies gate and strobe
// RQ8 - erase pulse 1 to 10 ms
// RQ9 - write pulse 1 to 10 ms
// RQ10 - wait 5 us after raising supply
// RQ11 - count wear per byte, limit 10000
// RQ12 - erase clears whole array to zeros
// RQ13 - write only sets bits, erase first
// RQ14 - read data latched until strobe high
// RQ15 - device floats data at programming supply
// RQ16 - host sequences operations as state machine
`timescale 1ns/1ps
module eeprom_host (
	clk,
	rst_b,
	req_valid,
	req_ready,
	req_op,
	req_addr,
	req_data,
	rsp_valid,
	rsp_data,
	rsp_worn,
	mem_addr,
	mem_data_in,
	mem_data_out,
	mem_data_oe_b,
	mem_select,
	mem_gate_b,
	mem_strobe_b,
	supply_prog
);
`include "eeprom_host_consts.vh"
	input  wire               clk;           // 40 MHz clock
	input  wire               rst_b;         // sync reset, active low
	input  wire               req_valid;     // request offered
	output wire               req_ready;     // controller idle
	input  wire [1:0]         req_op;        // read, erase or write
	input  wire [`ADDR_W-1:0] req_addr;      // byte address
	input  wire [`DATA_W-1:0] req_data;      // write data
	output reg                rsp_valid;     // one-cycle done pulse
	output reg  [`DATA_W-1:0] rsp_data;      // read data
	output reg                rsp_worn;      // write past endurance
	output reg  [`ADDR_W-1:0] mem_addr;      // device address pins
	input  wire [`DATA_W-1:0] mem_data_in;   // data bus sampled
	output reg  [`DATA_W-1:0] mem_data_out;  // data bus driven
	output reg                mem_data_oe_b; // low while host drives
	output reg                mem_select;    // chip select, high on
	output reg                mem_gate_b;    // output gate / erase
	output reg                mem_strobe_b;  // access strobe / write
	output reg                supply_prog;   // high: programming supply
	// state codes, one-hot
	localparam [7:0] S_IDLE  = 8'h01;
	localparam [7:0] S_RSET  = 8'h02; // read address setup
	localparam [7:0] S_RACC  = 8'h04; // read access wait
	localparam [7:0] S_VUP   = 8'h08; // supply raise settle
	localparam [7:0] S_PSET  = 8'h10; // address/data setup
	localparam [7:0] S_PULSE = 8'h20; // erase or write pulse
	localparam [7:0] S_HOLD  = 8'h40; // hold after pulse
	localparam [7:0] S_VDN   = 8'h80; // supply lowered or read deselected, recover
	reg  [7:0]          state;      // current state
	reg  [1:0]          op;         // latched operation
	reg                 t_load;     // timer start
	reg  [`WAIT_W-1:0]  t_count;    // timer length
	wire                t_done;     // timer expired
	reg  [`WEAR_W-1:0]  wear [0:`ARRAY_BYTES-1]; // cycles per byte
	reg  [`ADDR_W:0]    clr_idx;    // wear clear walker
	wire                clr_busy;   // wear table being cleared
	// cycle-count narrowing for the timer
	function [`WAIT_W-1:0] cyc;
		input integer n;
		begin
			cyc = n[`WAIT_W-1:0];
		end
	endfunction
	assign clr_busy  = !clr_idx[`ADDR_W];
	assign req_ready = (state == S_IDLE) && !clr_busy;
	wait_timer u_timer (
		.clk   (clk),
		.rst_b (rst_b),
		.load  (t_load),
		.count (t_count),
		.done  (t_done)
	);
	// ---------------------------------------------
	// wear table: cleared after reset, bumped per write
	// ---------------------------------------------
	always @(posedge clk) begin
		if (!rst_b)
			clr_idx <= {(`ADDR_W+1){1'b0}};
		else if (clr_busy) begin
			wear[clr_idx[`ADDR_W-1:0]] <= {`WEAR_W{1'b0}};
			clr_idx <= clr_idx + 1'b1;
		end else if (state == S_PULSE && t_done && op == `OP_WRITE
			&& wear[mem_addr] != `ENDURANCE)
			wear[mem_addr] <= wear[mem_addr] + 1'b1; // [RQ11]
	end
	// ---------------------------------------------
	// sequencer
	// ---------------------------------------------
	always @(posedge clk) begin
		if (!rst_b) begin
			state         <= S_IDLE;
			op            <= `OP_READ;
			t_load        <= 1'b0;
			t_count       <= {`WAIT_W{1'b0}};
			rsp_valid     <= 1'b0;
			rsp_data      <= {`DATA_W{1'b0}};
			rsp_worn      <= 1'b0;
			mem_addr      <= {`ADDR_W{1'b0}};
			mem_data_out  <= {`DATA_W{1'b0}};
			mem_data_oe_b <= 1'b1;
			mem_select    <= 1'b0;
			mem_gate_b    <= 1'b1;
			mem_strobe_b  <= 1'b1;
			supply_prog   <= 1'b0;
		end else begin
			t_load    <= 1'b0;
			rsp_valid <= 1'b0;
			case (state)
			S_IDLE: begin
				if (req_valid && req_ready) begin
					op           <= req_op;
					mem_addr     <= req_addr;        // [RQ1]
					mem_data_out <= req_data;
					mem_select   <= 1'b1;            // [RQ7]
					t_load       <= 1'b1;
					if (req_op == `OP_READ) begin
						t_count <= cyc(`SETUP_CYC);
						state   <= S_RSET;           // [RQ4]
					end else begin
						supply_prog <= 1'b1;         // [RQ2]
						t_count     <= cyc(`VPS_CYC);
						state       <= S_VUP;        // [RQ16]
					end
				end
			end
			S_RSET: if (t_done && !t_load) begin
				mem_strobe_b <= 1'b0;                // [RQ5]
				mem_gate_b   <= 1'b0;                // [RQ6]
				t_load       <= 1'b1;
				t_count      <= cyc(`READ_CYC);
				state        <= S_RACC;
			end
			S_RACC: if (t_done && !t_load) begin
				rsp_data     <= mem_data_in;         // [RQ14]
				rsp_valid    <= 1'b1;
				rsp_worn     <= 1'b0;
				mem_strobe_b <= 1'b1;
				mem_gate_b   <= 1'b1;
				mem_select   <= 1'b0;
				t_load       <= 1'b1;
				t_count      <= cyc(`CEH_CYC);
				state        <= S_VDN;
			end
			S_VUP: if (t_done && !t_load) begin     // [RQ10]
				// device floats its bus now, host may drive
				if (op == `OP_WRITE)
					mem_data_oe_b <= 1'b0;          // [RQ15]
				t_load  <= 1'b1;
				t_count <= cyc(`SETUP_CYC);
				state   <= S_PSET;
			end
			S_PSET: if (t_done && !t_load) begin
				if (op == `OP_ERASE)
					mem_gate_b   <= 1'b0;           // [RQ3] [RQ12]
				else
					mem_strobe_b <= 1'b0;           // [RQ3] [RQ13]
				t_load  <= 1'b1;
				t_count <= cyc(`PULSE_CYC);         // [RQ8] [RQ9]
				state   <= S_PULSE;
			end
			S_PULSE: if (t_done && !t_load) begin
				mem_gate_b   <= 1'b1;
				mem_strobe_b <= 1'b1;
				rsp_worn     <= (op == `OP_WRITE) &&
					(wear[mem_addr] == `ENDURANCE); // [RQ11]
				t_load  <= 1'b1;
				t_count <= cyc(`SETUP_CYC);
				state   <= S_HOLD;
			end
			S_HOLD: if (t_done && !t_load) begin
				mem_data_oe_b <= 1'b1;
				mem_select    <= 1'b0;
				supply_prog   <= 1'b0;              // [RQ4]
				t_load        <= 1'b1;
				t_count       <= cyc(`VPS_CYC);
				state         <= S_VDN;
			end
			S_VDN: if (t_done && !t_load) begin
				if (op != `OP_READ)
					rsp_valid <= 1'b1;
				state <= S_IDLE;
			end
			default: state <= S_IDLE;
			endcase
		end
	end
endmodule

// ### sim/eeprom_host_sva.sv
// assertions on the eeprom host pins
`timescale 1ns/1ps
module eeprom_host_sva (
	input wire clk,
	input wire rst_b,
	input wire rsp_valid,
	input wire mem_data_oe_b,
	input wire mem_select,
	input wire mem_gate_b,
	input wire mem_strobe_b,
	input wire supply_prog
);
	wire       pls;   // erase or write pulse active
	reg [19:0] p_cnt; // pulse length so far
	reg [19:0] v_cnt; // cycles at prog supply
	assign pls = supply_prog && !(mem_gate_b && mem_strobe_b);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	// ----------------
	// helper counters
	// ----------------
	always @(posedge clk) begin
		p_cnt <= (rst_b && pls) ? p_cnt + 20'h1 : 20'h0;
		v_cnt <= (rst_b && supply_prog) ? v_cnt + 20'h1 : 20'h0;
	end
	sequence rd_go;
		$fell(mem_strobe_b) && !supply_prog;
	endsequence
	chk_gate_select: assert property (
		!mem_gate_b |-> mem_select) else $error("gate unselected");
	chk_strobe_select: assert property (
		!mem_strobe_b |-> mem_select) else $error("strobe unselected");
	chk_erase_shape: assert property (
		supply_prog && !mem_gate_b |-> mem_strobe_b)
		else $error("strobe low in erase");
	chk_write_shape: assert property (
		supply_prog && !mem_strobe_b |-> mem_gate_b && !mem_data_oe_b)
		else $error("bad write pulse");
	chk_read_supply: assert property (
		!mem_gate_b && !mem_strobe_b |-> !supply_prog)
		else $error("read at prog supply");
	chk_pulse_width: assert property (
		$fell(pls) |-> p_cnt >= 20'h09C40 && p_cnt <= 20'h61A80)
		else $error("pulse width off");
	chk_supply_settle: assert property (
		$rose(pls) |-> v_cnt >= 20'h000C8) else $error("no settle");
	chk_read_answer: assert property (
		rd_go |-> ##[32:200] rsp_valid) else $error("read no answer");
	chk_drive_prog: assert property (
		!mem_data_oe_b |-> supply_prog && mem_gate_b)
		else $error("host drives in read");
endmodule
bind eeprom_host eeprom_host_sva i_sva (.clk, .rst_b, .rsp_valid,
	.mem_data_oe_b, .mem_select, .mem_gate_b, .mem_strobe_b, .supply_prog);

// ### sim/eeprom_model.sv
// behavioural 512x8 eeprom on the host pins
`timescale 1ns/1ps
module eeprom_model (
	select,
	gate_b,
	strobe_b,
	supply_prog,
	addr,
	data_in,
	q,
	q_oe
);
	input  wire       select;      // chip select
	input  wire       gate_b;      // output gate / erase
	input  wire       strobe_b;    // access strobe / write
	input  wire       supply_prog; // prog supply
	input  wire [8:0] addr;        // byte address
	input  wire [7:0] data_in;     // bus level
	output reg  [7:0] q;           // latched read data
	output wire       q_oe;        // device drives bus
	reg  [7:0] mem [0:511]; // byte array
	reg  [8:0] a_lat;       // address at strobe fall
	integer    i;           // loop index
	// start pattern, zero only at 0x186 and 0x187, so erase shows
	initial for (i = 0; i < 512; i = i + 1) mem[i] = i[8:1] ^ 8'hC3;
	// whole array erase
	always @(negedge gate_b) if (select && supply_prog)
		for (i = 0; i < 512; i = i + 1) mem[i] = 8'h00;
	// address capture, read latch
	always @(negedge strobe_b) if (select) begin
		a_lat = addr;
		if (!supply_prog) q = mem[addr];
	end
	// write only sets bits
	always @(posedge strobe_b) if (select && supply_prog)
		mem[a_lat] = mem[a_lat] | data_in;
	assign q_oe = select && !gate_b && !strobe_b && !supply_prog;
endmodule

// ### sim/eeprom_host_tb.sv
// testbench for the eeprom host controller
`timescale 1ns/1ps
`include "eeprom_host_consts.vh"
module eeprom_host_tb;
	reg        clk = 1'b0;       // 40 MHz
	reg        rst_b = 1'b0;     // sync reset
	reg        req_valid = 1'b0; // request strobe
	reg  [1:0] req_op = 2'h0;    // operation
	reg  [8:0] req_addr = 9'h000;
	reg  [7:0] req_data = 8'h00;
	reg  [7:0] last = 8'h00;     // bus history
	wire       req_ready, rsp_valid, rsp_worn, mem_data_oe_b, dev_oe;
	wire       mem_select, mem_gate_b, mem_strobe_b, supply_prog;
	wire [8:0] mem_addr;
	wire [7:0] rsp_data, mem_data_out, dev_q, bus;
	integer    num_errors = 0;
	integer    compares = 0;
	always #12.5 clk = ~clk;
	// floating bus toggles each cycle
	assign bus = !mem_data_oe_b ? mem_data_out : dev_oe ? dev_q : ~last;
	always @(posedge clk) last <= bus;
	eeprom_host i_dut (.clk, .rst_b, .req_valid, .req_ready, .req_op,
		.req_addr, .req_data, .rsp_valid, .rsp_data, .rsp_worn, .mem_addr,
		.mem_data_in(bus), .mem_data_out, .mem_data_oe_b, .mem_select,
		.mem_gate_b, .mem_strobe_b, .supply_prog);
	eeprom_model i_mem (.select(mem_select), .gate_b(mem_gate_b),
		.strobe_b(mem_strobe_b), .supply_prog, .addr(mem_addr),
		.data_in(bus), .q(dev_q), .q_oe(dev_oe));
	task results; begin
		if (num_errors == 0 && compares > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	end endtask
	task check(input string nm, input [7:0] e, input [7:0] g); begin
		compares = compares + 1;
		if (g !== e) begin
			$display("BAD %s exp %h got %h", nm, e, g);
			num_errors = num_errors + 1;
		end
	end endtask
	// one request, waits for the done pulse
	task do_op(input [1:0] op, input [8:0] a, input [7:0] d);
		integer n;
		begin
			req_valid <= 1'b1;
			req_op <= op;
			req_addr <= a;
			req_data <= d;
			n = 0;
			do begin @(posedge clk); n = n + 1; end
			while (req_ready !== 1'b1 && n < 1000);
			req_valid <= 1'b0;
			do begin @(posedge clk); n = n + 1; end
			while (rsp_valid !== 1'b1 && n < 50000);
			if (n >= 50000) begin
				$display("BAD rsp_valid exp 1 got 0");
				num_errors = num_errors + 1;
				results;
			end
		end
	endtask
	task t_idle; begin
		check("pins", 8'h0E, {3'h0, mem_select, mem_gate_b, mem_strobe_b,
			mem_data_oe_b, supply_prog});
		check("ready", 8'h00, {7'h0, req_ready});
	end endtask
	task t_read_init; begin
		do_op(`OP_READ, 9'h1A5, 8'h00);
		check("rd hi", 8'h11, rsp_data);
		do_op(`OP_READ, 9'h0A5, 8'h00);
		check("rd lo", 8'h91, rsp_data);
	end endtask
	task t_erase; begin
		do_op(`OP_ERASE, 9'h000, 8'h00);
		do_op(`OP_READ, 9'h1A5, 8'h00);
		check("erased", 8'h00, rsp_data);
	end endtask
	task t_write; begin
		do_op(`OP_WRITE, 9'h1A5, 8'hA5);
		check("worn", 8'h00, {7'h0, rsp_worn});
		do_op(`OP_READ, 9'h1A5, 8'h00);
		check("written", 8'hA5, rsp_data);
	end endtask
	initial begin
		repeat (3) @(posedge clk);
		rst_b <= 1'b1;
		@(posedge clk);
		t_idle;
		t_read_init;
		t_erase;
		t_write;
		results;
	end
endmodule
